// ===== logic/kmc_keypad_menu.sv
// keypad menu controller: debounce, menu states, readout select, motor gating
`timescale 1ns/1ns
module kmc_keypad_menu #(
  parameter int unsigned TICK_CYCLES = kmc_pkg::TICK_CYCLES,
  parameter int unsigned DEBOUNCE_MS = kmc_pkg::DEBOUNCE_MS,
  parameter int unsigned HOLD_MS     = kmc_pkg::HOLD_MS,
  parameter int unsigned REPEAT_MS   = kmc_pkg::REPEAT_MS,
  parameter int unsigned IDLE_MS     = kmc_pkg::IDLE_MS,
  parameter int unsigned BLINK_MS    = kmc_pkg::BLINK_MS,
  parameter int unsigned BEEP_MS     = kmc_pkg::BEEP_MS,
  parameter int unsigned NUM_FUNCS   = kmc_pkg::NUM_FUNCS,
  parameter int unsigned HELP_PAGES  = kmc_pkg::HELP_PAGES
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire kmc_pkg::kmc_keys_s            keys,
  input  wire logic                          bypass_running,
  input  wire logic                          fault_active,
  input  wire logic [7:0]                    thermal_pct,
  input  wire logic [kmc_pkg::VALUE_W-1:0]   stored_value,
  input  wire logic [kmc_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [kmc_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [kmc_pkg::DATA_W-1:0]    reg_rdata,
  output kmc_pkg::kmc_disp_s                 disp,
  output logic                               beep,
  output logic                               store_req,
  output logic      [4:0]                    store_index,
  output logic      [kmc_pkg::VALUE_W-1:0]   store_value,
  output kmc_pkg::kmc_motor_s                motor
);
  localparam int unsigned TICK_W  = $clog2(TICK_CYCLES + 1);
  localparam int unsigned DEB_W   = $clog2(DEBOUNCE_MS + 1);
  localparam int unsigned HOLD_W  = $clog2(HOLD_MS + 1);
  localparam int unsigned IDLE_W  = $clog2(IDLE_MS + 1);
  localparam int unsigned BLINK_W = $clog2(BLINK_MS + 1);
  localparam int unsigned BEEP_W  = $clog2(BEEP_MS + 1);
  localparam int unsigned NK      = kmc_pkg::NUM_KEYS;

  // modular step of a menu position, shared by index, help page and readout
  function automatic logic [4:0] wrap_step(input logic [4:0] cur, input logic up,
                                           input int unsigned n);
    if (up)
      return (cur == 5'(n - 1)) ? 5'h00 : cur + 5'h01;
    return (cur == 5'h00) ? 5'(n - 1) : cur - 5'h01;
  endfunction : wrap_step

  kmc_pkg::kmc_state_e   state;
  kmc_pkg::kmc_readout_e readout;
  logic [TICK_W-1:0]     tick_cnt;
  logic                  tick;
  logic [NK-1:0]         raw;
  logic [NK-1:0]         stable;
  logic [NK-1:0]         press;
  logic [DEB_W-1:0]      deb_cnt [NK];
  logic [HOLD_W-1:0]     hold_cnt;
  logic                  rep;
  logic [IDLE_W-1:0]     idle_cnt;
  logic [4:0]            func_idx;
  logic [2:0]            help_page;
  logic [kmc_pkg::VALUE_W-1:0] edit_value;
  logic [BLINK_W-1:0]    blink_cnt;
  logic                  colon_on;
  logic [2:0]            beep_phase;
  logic [BEEP_W-1:0]     beep_cnt;
  logic                  msg_stored;
  logic [2:0]            ctrl_src;
  logic                  overload;
  logic                  ev_confirm;
  logic                  ev_set;
  logic                  ev_run;
  logic                  ev_stop;
  logic                  ev_up;
  logic                  ev_down;
  logic                  any_key;
  logic                  timeout;
  logic                  changed;
  logic                  keypad_ok;
  logic                  in_setting;

  assign raw        = keys;
  assign ev_confirm = press[kmc_pkg::K_CONFIRM];
  assign ev_set     = press[kmc_pkg::K_SET];
  assign ev_run     = press[kmc_pkg::K_RUN];
  assign ev_stop    = press[kmc_pkg::K_STOP];
  assign ev_up      = press[kmc_pkg::K_UP] | (rep & stable[kmc_pkg::K_UP]);
  assign ev_down    = press[kmc_pkg::K_DOWN] | (rep & stable[kmc_pkg::K_DOWN]);
  assign any_key    = (|press) | rep;
  assign in_setting = (state == kmc_pkg::ST_BROWSE) || (state == kmc_pkg::ST_EDIT);
  assign timeout    = in_setting && tick && (idle_cnt == IDLE_W'(IDLE_MS - 1));
  assign changed    = edit_value != stored_value;
  assign keypad_ok  = kmc_pkg::keypad_allowed(ctrl_src);

  // millisecond timebase; every slow timer counts these ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (clk_en) begin
      tick <= tick_cnt == TICK_W'(TICK_CYCLES - 1);
      if (tick_cnt == TICK_W'(TICK_CYCLES - 1))
        tick_cnt <= '0;
      else
        tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  // a key must sit at its new level for the whole window before it counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stable <= '0;
      press  <= '0;
      for (int i = 0; i < NK; i++)
        deb_cnt[i] <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NK; i++) begin
        press[i] <= 1'b0;
        if (raw[i] == stable[i]) begin
          deb_cnt[i] <= '0;
        end else if (tick) begin
          if (deb_cnt[i] == DEB_W'(DEBOUNCE_MS - 1)) begin
            stable[i]  <= raw[i];
            press[i]   <= raw[i];
            deb_cnt[i] <= '0;
          end else begin
            deb_cnt[i] <= deb_cnt[i] + DEB_W'(1);
          end
        end
      end
    end
  end

  // hold-to-repeat; both arrows held together never repeat
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= '0;
      rep      <= 1'b0;
    end else if (clk_en) begin
      rep <= 1'b0;
      if (!(stable[kmc_pkg::K_UP] ^ stable[kmc_pkg::K_DOWN])) begin
        hold_cnt <= '0;
      end else if (tick) begin
        if (hold_cnt == HOLD_W'(HOLD_MS - 1)) begin
          rep      <= 1'b1;
          hold_cnt <= HOLD_W'(HOLD_MS - REPEAT_MS);
        end else begin
          hold_cnt <= hold_cnt + HOLD_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      idle_cnt <= '0;
    else if (clk_en) begin
      if (!in_setting || any_key)
        idle_cnt <= '0;
      else if (tick)
        idle_cnt <= idle_cnt + IDLE_W'(1);
    end
  end

  // menu state; stop and idle timeout beat confirm, confirm beats set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= kmc_pkg::ST_READY;
      store_req   <= 1'b0;
      store_index <= '0;
      store_value <= '0;
    end else if (clk_en) begin
      store_req <= 1'b0;
      case (state)
        kmc_pkg::ST_READY: begin
          if (ev_confirm)
            state <= kmc_pkg::ST_HELP;
          else if (ev_set)
            state <= kmc_pkg::ST_BROWSE;
        end
        kmc_pkg::ST_HELP: begin
          if (ev_confirm || ev_stop)
            state <= kmc_pkg::ST_READY;
        end
        kmc_pkg::ST_BROWSE: begin
          if (ev_stop || timeout || ev_confirm)
            state <= kmc_pkg::ST_READY;
          else if (ev_set)
            state <= kmc_pkg::ST_EDIT;
        end
        kmc_pkg::ST_EDIT: begin
          if (ev_stop || timeout) begin
            state <= kmc_pkg::ST_READY;
          end else if (ev_confirm) begin
            state       <= kmc_pkg::ST_READY;
            store_req   <= changed;
            store_index <= func_idx;
            store_value <= edit_value;
          end else if (ev_set) begin
            state <= kmc_pkg::ST_BROWSE;
          end
        end
        default: state <= kmc_pkg::ST_READY;
      endcase
    end
  end

  // outside edit the working copy follows storage, so a cancel restores it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edit_value <= '0;
    end else if (clk_en) begin
      if (state != kmc_pkg::ST_EDIT || ev_stop || timeout)
        edit_value <= stored_value;
      else if (ev_up && !ev_down && edit_value != kmc_pkg::VALUE_MAX)
        edit_value <= edit_value + 10'h001;
      else if (ev_down && !ev_up && edit_value != 10'h000)
        edit_value <= edit_value - 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_idx <= '0;
    end else if (clk_en && state == kmc_pkg::ST_BROWSE && !ev_stop && !ev_set) begin
      if (ev_up != ev_down)
        func_idx <= wrap_step(func_idx, ev_up, NUM_FUNCS);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      help_page <= '0;
    end else if (clk_en) begin
      if (state != kmc_pkg::ST_HELP)
        help_page <= '0;
      else if (ev_up != ev_down)
        help_page <= 3'(wrap_step({2'h0, help_page}, ev_up, HELP_PAGES));
    end
  end

  // readout falls back to current whenever bypass ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readout <= kmc_pkg::RO_CURRENT;
    end else if (clk_en) begin
      if (!bypass_running)
        readout <= kmc_pkg::RO_CURRENT;
      else if (state == kmc_pkg::ST_READY && ev_up != ev_down)
        readout <= kmc_pkg::kmc_readout_e'(2'(wrap_step({3'h0, readout}, ev_up,
                                                        kmc_pkg::NUM_READOUTS)));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= '0;
      colon_on  <= 1'b1;
    end else if (clk_en) begin
      if (state != kmc_pkg::ST_EDIT) begin
        blink_cnt <= '0;
        colon_on  <= 1'b1;
      end else if (tick) begin
        if (blink_cnt == BLINK_W'(BLINK_MS - 1)) begin
          blink_cnt <= '0;
          colon_on  <= !colon_on;
        end else begin
          blink_cnt <= blink_cnt + BLINK_W'(1);
        end
      end
    end
  end

  // two beeps: phases 1 and 3 sound, message stays up until the last phase ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beep_phase <= '0;
      beep_cnt   <= '0;
      beep       <= 1'b0;
      msg_stored <= 1'b0;
    end else if (clk_en) begin
      if (store_req) begin
        beep_phase <= 3'h1;
        beep_cnt   <= '0;
        beep       <= 1'b1;
        msg_stored <= 1'b1;
      end else if (beep_phase != 3'h0 && tick) begin
        if (beep_cnt == BEEP_W'(BEEP_MS - 1)) begin
          beep_cnt <= '0;
          if (beep_phase == 3'(kmc_pkg::BEEP_PHASES)) begin
            beep_phase <= 3'h0;
            msg_stored <= 1'b0;
          end else begin
            beep_phase <= beep_phase + 3'h1;
            beep       <= !beep_phase[0];
          end
        end else begin
          beep_cnt <= beep_cnt + BEEP_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      motor    <= '0;
      overload <= 1'b0;
    end else if (clk_en) begin
      overload            <= thermal_pct > kmc_pkg::THERMAL_TRIP_PCT;
      motor.overload_trip <= thermal_pct > kmc_pkg::THERMAL_TRIP_PCT;
      motor.start         <= ev_run && keypad_ok;
      motor.stop          <= ev_stop && keypad_ok && !fault_active;
      motor.fault_reset   <= ev_stop && fault_active;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disp <= '0;
    end else if (clk_en) begin
      disp.state               <= state;
      disp.readout             <= readout;
      disp.function_code_index <= func_idx;
      disp.value               <= edit_value;
      disp.colon_on            <= colon_on;
      disp.colon_blink         <= state == kmc_pkg::ST_EDIT;
      disp.help_page           <= help_page;
      disp.msg_stored          <= msg_stored;
    end
  end

  // register port: read data valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_src <= kmc_pkg::CTRL_SRC_RST;
    end else if (clk_en && reg_wr && reg_addr == kmc_pkg::CTRL_OFS) begin
      ctrl_src <= reg_wdata[kmc_pkg::CTRL_SRC_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_rd && reg_addr == kmc_pkg::CTRL_OFS) begin
        reg_rdata[kmc_pkg::CTRL_SRC_LSB +: 3] <= ctrl_src;
      end else if (reg_rd && reg_addr == kmc_pkg::STATUS_OFS) begin
        reg_rdata[kmc_pkg::ST_STATE_LSB +: 2] <= state;
        reg_rdata[kmc_pkg::ST_BLINK_BIT]      <= state == kmc_pkg::ST_EDIT;
        reg_rdata[kmc_pkg::ST_OVL_BIT]        <= overload;
        reg_rdata[kmc_pkg::ST_KEYPAD_BIT]     <= keypad_ok;
        reg_rdata[kmc_pkg::ST_MSG_BIT]        <= msg_stored;
        reg_rdata[kmc_pkg::ST_FUNC_LSB +: 5]  <= func_idx;
        reg_rdata[kmc_pkg::ST_READ_LSB +: 2]  <= readout;
      end
    end
  end

  // helper: beeps counted since the last store
  logic       beep_d;
  logic [1:0] beep_edges;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beep_d     <= 1'b0;
      beep_edges <= '0;
    end else if (clk_en) begin
      beep_d <= beep;
      if (store_req)
        beep_edges <= '0;
      else if (beep && !beep_d)
        beep_edges <= beep_edges + 2'h1;
    end
  end

  sequence s_ready_confirm;
    clk_en && state == kmc_pkg::ST_READY && ev_confirm;
  endsequence
  sequence s_edit_save;
    clk_en && state == kmc_pkg::ST_EDIT && ev_confirm && !ev_stop && !timeout && changed;
  endsequence
  sequence s_edit_cancel;
    clk_en && state == kmc_pkg::ST_EDIT && ev_set && !ev_confirm && !ev_stop && !timeout;
  endsequence

  help_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_ready_confirm |=> state == kmc_pkg::ST_HELP)
    else $error("confirm in ready did not open help");
  edit_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_edit_save |=> store_req && store_value == $past(edit_value) && state == kmc_pkg::ST_READY)
    else $error("changed value not stored on confirm");
  browse_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && state == kmc_pkg::ST_READY && ev_set && !ev_confirm
    |=> state == kmc_pkg::ST_BROWSE)
    else $error("set in ready did not open browse");
  index_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && state == kmc_pkg::ST_BROWSE && ev_up && !ev_down && !ev_set && !ev_stop
    |=> func_idx == (($past(func_idx) == 5'(NUM_FUNCS - 1)) ? 5'h00 : $past(func_idx) + 5'h01))
    else $error("up in browse did not advance index");
  edit_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && state == kmc_pkg::ST_BROWSE && ev_set && !ev_stop && !ev_confirm && !timeout
    |=> state == kmc_pkg::ST_EDIT ##1 disp.colon_blink)
    else $error("set in browse did not start blinking edit");
  beep_twice_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(msg_stored) |-> beep_edges == 2'h2)
    else $error("store message ended without two beeps");
  edit_cancel_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_edit_cancel |=> state == kmc_pkg::ST_BROWSE && !store_req ##1 edit_value == stored_value)
    else $error("cancel did not restore value");
  stop_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && in_setting && ev_stop |=> state == kmc_pkg::ST_READY && !store_req)
    else $error("stop did not leave menu unsaved");
  run_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && ev_run |=> motor.start == $past(keypad_ok))
    else $error("run gating by control source wrong");
  fault_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && ev_stop && fault_active |=> motor.fault_reset && !motor.stop)
    else $error("stop in fault did not act as reset");
  overload_trip_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && thermal_pct > 8'h64 |=> motor.overload_trip)
    else $error("thermal above limit did not trip");
endmodule : kmc_keypad_menu

// ===== pkg/kmc_pkg.sv
// constants, types and helpers of the keypad menu controller
package kmc_pkg;
  // clock and timebase
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned TICK_TIME_MS = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_TIME_MS;

  // times in milliseconds unless named otherwise
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned HOLD_MS     = 1000;
  localparam int unsigned REPEAT_MS   = 100;
  localparam int unsigned IDLE_TIME_S = 120;
  localparam int unsigned IDLE_MS     = IDLE_TIME_S * 1000;
  localparam int unsigned BLINK_MS    = 250;
  localparam int unsigned BEEP_MS     = 100;
  localparam int unsigned BEEP_PHASES = 4;

  // menu contents
  localparam int unsigned NUM_FUNCS  = 21;
  localparam int unsigned HELP_PAGES = 8;
  localparam int unsigned NUM_READOUTS = 3;
  localparam int unsigned VALUE_W    = 10;
  localparam logic [9:0]  VALUE_MAX  = 10'h3E7;
  localparam logic [7:0]  THERMAL_TRIP_PCT = 8'h64;

  // key bit positions inside kmc_keys_s
  localparam int unsigned K_DOWN    = 0;
  localparam int unsigned K_UP      = 1;
  localparam int unsigned K_STOP    = 2;
  localparam int unsigned K_RUN     = 3;
  localparam int unsigned K_SET     = 4;
  localparam int unsigned K_CONFIRM = 5;
  localparam int unsigned NUM_KEYS  = 6;

  // register map
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0]  CTRL_OFS   = 4'h0;
  localparam logic [3:0]  STATUS_OFS = 4'h4;
  localparam int unsigned CTRL_SRC_LSB  = 0;
  localparam logic [2:0]  CTRL_SRC_RST  = 3'h4;
  localparam int unsigned ST_STATE_LSB  = 0;
  localparam int unsigned ST_BLINK_BIT  = 2;
  localparam int unsigned ST_OVL_BIT    = 3;
  localparam int unsigned ST_KEYPAD_BIT = 4;
  localparam int unsigned ST_MSG_BIT    = 5;
  localparam int unsigned ST_FUNC_LSB   = 8;
  localparam int unsigned ST_READ_LSB   = 16;

  typedef enum logic [1:0] {ST_READY, ST_HELP, ST_BROWSE, ST_EDIT} kmc_state_e;
  typedef enum logic [1:0] {RO_CURRENT, RO_POWER, RO_THERMAL} kmc_readout_e;

  typedef struct packed {
    logic confirm;
    logic set;
    logic run;
    logic stop;
    logic up;
    logic down;
  } kmc_keys_s;

  typedef struct packed {
    kmc_state_e   state;
    kmc_readout_e readout;
    logic [4:0]   function_code_index;
    logic [9:0]   value;
    logic         colon_on;
    logic         colon_blink;
    logic [2:0]   help_page;
    logic         msg_stored;
  } kmc_disp_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic fault_reset;
    logic overload_trip;
  } kmc_motor_s;

  function automatic logic keypad_allowed(input logic [2:0] code);
    return (code == 3'h0) || (code == 3'h1) || (code == 3'h4) || (code == 3'h5);
  endfunction : keypad_allowed
endpackage : kmc_pkg

// ===== dv/kmc_operator.sv
// operator model: presses and holds front-panel keys
`timescale 1ns/1ns
module kmc_operator #(
  parameter int TICK = 4
) (
  input  wire logic               clk,
  output wire kmc_pkg::kmc_keys_s keys
);
  logic [5:0] kv = 6'h00;
  assign keys = kmc_pkg::kmc_keys_s'(kv);
  // press outlasts the debounce window, and the release settles before the next press
  task automatic press(input int k, input int ms);
    @(posedge clk);
    kv[k] <= 1'b1;
    repeat (ms * TICK) @(posedge clk);
    kv[k] <= 1'b0;
    repeat (24) @(posedge clk);
  endtask : press
endmodule : kmc_operator

// ===== dv/kmc_keypad_menu_test.sv
// self-checking testbench of the keypad menu controller
`timescale 1ns/1ns
module kmc_keypad_menu_test;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                byp = 1'b0;
  logic                flt = 1'b0;
  logic                wr = 1'b0;
  logic                rd = 1'b0;
  logic                bprev = 1'b0;
  logic                ce = 1'b1;
  logic [9:0]          sto = 10'h005;
  logic [4:0]          sidx;
  logic [3:0]          addr = 4'h0;
  logic [31:0]         wd = 32'h0;
  logic [7:0]          th = 8'h00;
  logic [31:0]         rdat;
  logic                beep;
  logic                sreq;
  logic [9:0]          sval;
  kmc_pkg::kmc_keys_s  keys;
  kmc_pkg::kmc_disp_s  disp;
  kmc_pkg::kmc_motor_s mot;
  int err_total = 0;
  int comparisons = 0;
  int n_run, n_stop, n_rst, n_st, n_bp;
  localparam int UP = kmc_pkg::K_UP, DN = kmc_pkg::K_DOWN, SET = kmc_pkg::K_SET;
  localparam int OK = kmc_pkg::K_CONFIRM, STP = kmc_pkg::K_STOP, RUN = kmc_pkg::K_RUN;
  // shortened timebase so that whole menu walks fit in a short run
  localparam int TC  = 4;
  localparam int DEB = 2;
  localparam int HLD = 10;
  localparam int REP = 3;
  localparam int IDL = 50;
  localparam int BLK = 3;
  localparam int BPM = 2;
  initial forever #2 clk = ~clk;
  kmc_operator #(.TICK(TC)) op_u (.clk(clk), .keys(keys));
  kmc_keypad_menu #(.TICK_CYCLES(TC), .DEBOUNCE_MS(DEB), .HOLD_MS(HLD), .REPEAT_MS(REP),
    .IDLE_MS(IDL), .BLINK_MS(BLK), .BEEP_MS(BPM)) dut_u (
    .clk(clk), .rst_n(rst_n), .clk_en(ce), .keys(keys), .bypass_running(byp),
    .fault_active(flt), .thermal_pct(th), .stored_value(sto), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .disp(disp), .beep(beep),
    .store_req(sreq), .store_index(sidx), .store_value(sval), .motor(mot));
  // pulses are tallied here so that no scenario has to catch a single cycle itself
  always @(posedge clk) begin
    n_run += mot.start;
    n_stop += mot.stop;
    n_rst += mot.fault_reset;
    n_st += sreq;
    n_bp += (beep && !bprev);
    bprev <= beep;
    // parameter storage takes the committed value
    if (sreq) sto <= sval;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: saw %0h, expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (!w) chk(rdat, d);
  endtask : bus
  task automatic prs(input int k);
    op_u.press(k, 5);
  endtask : prs
  task automatic t_menu;
    prs(OK);
    chk(disp.state, kmc_pkg::ST_HELP);
    prs(UP);
    chk(disp.help_page, 3'h1);
    prs(STP);
    chk(disp.state, kmc_pkg::ST_READY);
    prs(SET);
    chk(disp.state, kmc_pkg::ST_BROWSE);
    prs(UP);
    chk(disp.function_code_index, 5'h01);
    prs(DN);
    chk(disp.function_code_index, 5'h00);
    repeat (240) @(posedge clk);
    chk(disp.state, kmc_pkg::ST_READY);
    $display("menu test done");
  endtask : t_menu
  task automatic t_edit;
    logic c0;
    prs(SET);
    prs(UP);
    prs(SET);
    chk(disp.colon_blink, 1'b1);
    c0 = disp.colon_on;
    repeat (12) @(posedge clk);
    chk(disp.colon_on, !c0);
    prs(UP);
    chk(disp.value, 10'h006);
    n_st = 0;
    n_bp = 0;
    prs(OK);
    repeat (40) @(posedge clk);
    chk(sval, 10'h006);
    chk(sidx, 5'h01);
    chk(n_st, 1);
    chk(n_bp, 2);
    prs(SET);
    prs(SET);
    prs(UP);
    prs(SET);
    chk({disp.colon_blink, disp.value}, 11'h006);
    prs(OK);
    chk(disp.state, kmc_pkg::ST_READY);
    prs(SET);
    prs(SET);
    n_st = 0;
    op_u.press(UP, 25);
    // one press step plus five repeats before the release is debounced
    chk(disp.value, 10'h00C);
    prs(STP);
    chk(disp.state, kmc_pkg::ST_READY);
    chk(n_st, 0);
    $display("edit test done");
  endtask : t_edit
  task automatic t_src;
    bus(1'b0, 4'h0, 32'h4);
    bus(1'b0, 4'h8, 32'h0);
    bus(1'b0, 4'h4, 32'h110);
    ce <= 1'b0;
    prs(SET);
    bus(1'b1, 4'h0, 32'h6);
    @(posedge clk);
    ce <= 1'b1;
    chk(disp.state, kmc_pkg::ST_READY);
    bus(1'b0, 4'h0, 32'h4);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 4'h0, c);
      n_run = 0;
      n_stop = 0;
      prs(RUN);
      prs(STP);
      chk(n_run, (32'h33 >> c) & 1);
      chk(n_stop, (32'h33 >> c) & 1);
    end
    bus(1'b1, 4'h0, 32'h0);
    @(posedge clk);
    flt <= 1'b1;
    n_rst = 0;
    n_stop = 0;
    prs(STP);
    chk(n_rst, 1);
    chk(n_stop, 0);
    flt <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h4);
    $display("source test done");
  endtask : t_src
  task automatic t_disp;
    @(posedge clk);
    byp <= 1'b1;
    repeat (4) @(posedge clk);
    chk(disp.readout, kmc_pkg::RO_CURRENT);
    prs(UP);
    chk(disp.readout, kmc_pkg::RO_POWER);
    prs(UP);
    chk(disp.readout, kmc_pkg::RO_THERMAL);
    byp <= 1'b0;
    th <= 8'h65;
    repeat (4) @(posedge clk);
    chk(disp.readout, kmc_pkg::RO_CURRENT);
    chk(mot.overload_trip, 1'b1);
    th <= 8'h64;
    repeat (4) @(posedge clk);
    chk(mot.overload_trip, 1'b0);
    $display("display test done");
  endtask : t_disp
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_menu;
    t_edit;
    t_src;
    t_disp;
    end_sim;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    end_sim;
  end
endmodule : kmc_keypad_menu_test
